// ===== hw/bopd_regs.vh
`ifndef BOPD_REGS_VH
`define BOPD_REGS_VH
// Instruction word layout
`define BOPD_IW_W        14
`define BOPD_CLASS_HI    13
`define BOPD_CLASS_LO    12
`define BOPD_OP_HI       11
`define BOPD_OP_LO       8
`define BOPD_DEST_BIT    7
`define BOPD_FA_HI       6
`define BOPD_FA_LO       0
`define BOPD_BN_HI       9
`define BOPD_BN_LO       7
`define BOPD_CLASS_BYTE  2'h0
// Byte-oriented operation codes
`define BOPD_OP_MISC     4'h0
`define BOPD_OP_CLR      4'h1
`define BOPD_OP_SUB      4'h2
`define BOPD_OP_DEC      4'h3
`define BOPD_OP_IOR      4'h4
`define BOPD_OP_AND      4'h5
`define BOPD_OP_XOR      4'h6
`define BOPD_OP_ADD      4'h7
`define BOPD_OP_MOV      4'h8
`define BOPD_OP_COM      4'h9
`define BOPD_OP_INC      4'hA
`define BOPD_OP_DECSZ    4'hB
`define BOPD_OP_RRC      4'hC
`define BOPD_OP_RLC      4'hD
`define BOPD_OP_SWAP     4'hE
`define BOPD_OP_INCSZ    4'hF
// Timing: oscillator periods per instruction cycle
`define BOPD_PHASES      4
`define BOPD_PH_LAST     2'h3
// Reset values
`define BOPD_ACC_RST     8'h00
`define BOPD_FLAG_RST    1'b0
`endif

// ===== hw/bopd_alu.v
`timescale 1ns/1ps
`include "bopd_regs.vh"
// Combinational byte-operation datapath
module bopd_alu (
    input  wire [3:0] op,          // Operation code
    input  wire [7:0] acc,         // Accumulator operand
    input  wire [7:0] fval,        // File register operand
    input  wire       cin,         // Carry in
    output reg  [7:0] res,         // Result
    output reg        cout,        // Carry out
    output reg        dcout        // Digit carry out
);
    reg [8:0] sum;
    reg [4:0] nib;
    always @* begin
        sum   = 9'h000;
        nib   = 5'h00;
        res   = fval;
        cout  = cin;
        dcout = 1'b0;
        case (op)
            `BOPD_OP_ADD: begin // RULE15
                sum   = {1'b0, fval} + {1'b0, acc};
                nib   = {1'b0, fval[3:0]} + {1'b0, acc[3:0]};
                res   = sum[7:0];
                cout  = sum[8];
                dcout = nib[4];
            end
            `BOPD_OP_SUB: begin // RULE15
                // Carry is the inverted borrow, so f + ~w + 1
                sum   = {1'b0, fval} + {1'b0, ~acc} + 9'h001;
                nib   = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
                res   = sum[7:0];
                cout  = sum[8];
                dcout = nib[4];
            end
            `BOPD_OP_AND:   res = acc & fval; // RULE10
            `BOPD_OP_IOR:   res = acc | fval; // RULE10
            `BOPD_OP_XOR:   res = acc ^ fval; // RULE11
            `BOPD_OP_COM:   res = ~fval; // RULE15
            `BOPD_OP_DEC:   res = fval - 8'h01; // RULE15
            `BOPD_OP_DECSZ: res = fval - 8'h01; // RULE13
            `BOPD_OP_INC:   res = fval + 8'h01; // RULE15
            `BOPD_OP_INCSZ: res = fval + 8'h01; // RULE13
            `BOPD_OP_MOV:   res = fval; // RULE15
            `BOPD_OP_SWAP:  res = {fval[3:0], fval[7:4]}; // RULE15
            `BOPD_OP_RLC: begin // RULE12
                res  = {fval[6:0], cin};
                cout = fval[7];
            end
            `BOPD_OP_RRC: begin // RULE12
                res  = {cin, fval[7:1]};
                cout = fval[0];
            end
            `BOPD_OP_MISC:  res = acc;
            `BOPD_OP_CLR:   res = 8'h00;
            default:        res = fval;
        endcase
    end
endmodule // bopd_alu

// ===== hw/bopd_decoder.v
`timescale 1ns/1ps
`include "bopd_regs.vh"
// Behaviour
// RULE1: Each instruction is one 14-bit word
// RULE2: Destination bit picks accumulator or file
// RULE3: Seven-bit file address, 0x00 to 0x7F
// RULE4: Bit number selects bit within file
// RULE5: Literal field is eight or eleven bits
// RULE6: Don't-care bits never change execution
// RULE7: One cycle; skip or branch adds no-op
// RULE8: Instruction cycle equals four oscillator periods
// RULE9: Byte ops: 00, opcode, d, file address
// RULE10: AND/OR with file, zero flag only
// RULE11: XOR with file, zero flag only
// RULE12: Rotate through carry, carry only
// RULE13: Decrement/increment, skip when zero, no flags
// RULE14: Software avoids legacy option/direction loads
// RULE15: Add/sub full flags; others zero only; swap here changes no flag
// RULE16: Groups 0000/0001: move, clear, no-op
module bopd_decoder (
    input  wire        clk_sys,        // Oscillator clock
    input  wire        rst_n,          // Synchronous reset, active low
    input  wire [13:0] instr_word,     // Instruction word from program memory
    input  wire [7:0]  file_rdata,     // Addressed file register contents
    output wire        fetch_req,      // Pulse: next word is taken this cycle end
    output reg  [6:0]  file_addr,      // File register address
    output reg  [2:0]  bit_num,        // Bit number field
    output reg  [7:0]  lit8,           // Eight-bit literal field
    output reg  [10:0] lit11,          // Eleven-bit literal field
    output reg         file_we,        // Pulse: write file register
    output reg  [7:0]  file_wdata,     // File register write data
    output reg  [7:0]  acc_r,          // Working accumulator
    output reg         carry_flag,     // Carry flag
    output reg         digit_carry_flag, // Digit carry flag
    output reg         zero_flag,      // Zero flag
    output reg         skip_active,    // Level: current cycle is a forced no-op
    output reg  [1:0]  phase_r         // Oscillator period within cycle
);
    localparam ST_EXEC = 2'b01;
    localparam ST_NOP  = 2'b10;

    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [13:0] ir_r;
    wire [1:0]  iclass = ir_r[`BOPD_CLASS_HI:`BOPD_CLASS_LO]; // RULE1
    wire [3:0]  op     = ir_r[`BOPD_OP_HI:`BOPD_OP_LO]; // RULE9
    wire        dest   = ir_r[`BOPD_DEST_BIT];
    wire        byte_op = (iclass == `BOPD_CLASS_BYTE); // RULE9
    wire        last_ph = (phase_r == `BOPD_PH_LAST);
    wire [7:0]  res;
    wire        cout;
    wire        dcout;
    wire        exec    = last_ph && (state_r == ST_EXEC) && byte_op;
    wire        res_zero = (res == 8'h00);
    wire [15:0] op_hit;
    wire        upd_carry;
    wire        upd_dc;
    wire        upd_zero;
    wire        skip_op;
    reg  [6:0]  wr_addr_r;

    // One select line per byte operation code
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_op_hit
            assign op_hit[gi] = byte_op && (op == gi); // RULE9
        end
    endgenerate

    // Flag classes; swap and the skip pair are in none, so they keep every flag
    assign upd_carry = op_hit[`BOPD_OP_ADD] |
                       op_hit[`BOPD_OP_SUB] |
                       op_hit[`BOPD_OP_RLC] |
                       op_hit[`BOPD_OP_RRC]; // RULE12 RULE15

    assign upd_dc    = op_hit[`BOPD_OP_ADD] |
                       op_hit[`BOPD_OP_SUB]; // RULE15

    assign upd_zero  = op_hit[`BOPD_OP_ADD] |
                       op_hit[`BOPD_OP_SUB] |
                       op_hit[`BOPD_OP_AND] |
                       op_hit[`BOPD_OP_IOR] |
                       op_hit[`BOPD_OP_XOR] |
                       op_hit[`BOPD_OP_COM] |
                       op_hit[`BOPD_OP_DEC] |
                       op_hit[`BOPD_OP_INC] |
                       op_hit[`BOPD_OP_MOV]; // RULE10 RULE11 RULE15

    // Skip pair: only a zero result forces the following no-op
    assign skip_op   = op_hit[`BOPD_OP_DECSZ] |
                       op_hit[`BOPD_OP_INCSZ]; // RULE13

    assign fetch_req = last_ph;

    bopd_alu u_alu (
        .op    (op),
        .acc   (acc_r),
        .fval  (file_rdata),
        .cin   (carry_flag),
        .res   (res),
        .cout  (cout),
        .dcout (dcout)
    );

    // Operand fields are decoded for every class; unused ones are simply ignored
    always @* begin
        // The write pulse trails its instruction by one clock, so it
        // carries its own held address
        file_addr = file_we ? wr_addr_r : ir_r[`BOPD_FA_HI:`BOPD_FA_LO]; // RULE3 RULE2
        // Literal fields overlap the address bits, and the bit field the destination and opcode bits, on purpose
        bit_num   = ir_r[`BOPD_BN_HI:`BOPD_BN_LO]; // RULE4
        lit8      = ir_r[7:0]; // RULE5
        lit11     = ir_r[10:0]; // RULE5
    end

    // Four oscillator periods per instruction cycle
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1; // RULE8
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_EXEC: begin
                if (exec && res_zero &&
                    skip_op) begin
                    state_nxt = ST_NOP; // RULE7 RULE13
                end
            end
            ST_NOP: begin
                // The forced no-op lasts one full instruction cycle
                if (last_ph) begin
                    state_nxt = ST_EXEC; // RULE7
                end
            end
            default: state_nxt = ST_EXEC;
        endcase
    end

    // Control: state, instruction register and skip level
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r     <= ST_EXEC;
            ir_r        <= 14'h0000;
            skip_active <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            skip_active <= (state_nxt == ST_NOP); // RULE7
            // The word latched on the edge that enters the forced no-op is held through it, never executed
            if (last_ph) begin
                ir_r <= instr_word; // RULE1
            end
        end
    end

    // Accumulator takes results whose destination bit is clear
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_r <= `BOPD_ACC_RST;
        end else if (exec && !dest) begin
            case (op)
                `BOPD_OP_MISC: acc_r <= acc_r; // RULE16
                `BOPD_OP_CLR:  acc_r <= 8'h00; // RULE16 RULE6
                default:       acc_r <= res; // RULE2
            endcase
        end
    end

    // File write: the pulse stands one clock after the execute edge, when the
    // instruction register already holds the next word, so the address is kept
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            file_we    <= 1'b0;
            file_wdata <= 8'h00;
            wr_addr_r  <= 7'h00;
        end else begin
            file_we <= 1'b0;
            if (exec && dest) begin
                file_we   <= 1'b1; // RULE2
                wr_addr_r <= ir_r[`BOPD_FA_HI:`BOPD_FA_LO]; // RULE3
                case (op)
                    `BOPD_OP_MISC: file_wdata <= acc_r; // RULE16
                    `BOPD_OP_CLR:  file_wdata <= 8'h00; // RULE16
                    default:       file_wdata <= res; // RULE2
                endcase
            end
        end
    end

    // Flags move only for the operations of their class, and zero also for clear
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            carry_flag       <= `BOPD_FLAG_RST;
            digit_carry_flag <= `BOPD_FLAG_RST;
            zero_flag        <= `BOPD_FLAG_RST;
        end else if (exec) begin
            if (upd_carry) begin
                carry_flag <= cout; // RULE12 RULE15
            end
            if (upd_dc) begin
                digit_carry_flag <= dcout; // RULE15
            end
            // Clearing sets zero whatever the destination
            if (op_hit[`BOPD_OP_CLR]) begin
                zero_flag <= 1'b1; // RULE16
            end else if (upd_zero) begin
                zero_flag <= res_zero; // RULE10 RULE11 RULE15
            end
        end
    end
endmodule // bopd_decoder

// ===== verification/bopd_sva.sv
`timescale 1ns/1ps
module bopd_sva (
    input wire        clk_sys,          // Clock
    input wire        rst_n,            // Reset
    input wire [13:0] instr_word,       // Word
    input wire        fetch_req,        // Fetch
    input wire [6:0]  file_addr,        // Address
    input wire [2:0]  bit_num,          // Bit number
    input wire [7:0]  lit8,             // Literal
    input wire [10:0] lit11,            // Long literal
    input wire        file_we,          // Write
    input wire [7:0]  acc_r,            // Accumulator
    input wire        carry_flag,       // Carry
    input wire        digit_carry_flag, // Digit carry
    input wire        zero_flag,        // Zero
    input wire        skip_active,      // Skip
    input wire [1:0]  phase_r           // Phase
);
    wire [2:0] flg = {carry_flag, digit_carry_flag, zero_flag};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_PHASE: assert property ($past(rst_n) |-> phase_r == $past(phase_r) + 2'h1)
        else $error("phase step wrong");
    AST_FETCH: assert property (fetch_req |=> !fetch_req [*3] ##1 fetch_req)
        else $error("fetch spacing wrong");
    AST_WE: assert property (file_we |-> $past(fetch_req) ##1 !file_we)
        else $error("write pulse wrong");
    AST_QUIET: assert property ($past(rst_n) && !$past(fetch_req) |->
        $stable(acc_r) && $stable(flg))
        else $error("state moved off cycle end");
    AST_SKIP4: assert property ($rose(skip_active) |-> skip_active [*4] ##1 !skip_active)
        else $error("skip length wrong");
    AST_NOEXEC: assert property ($past(rst_n) && $fell(skip_active) |->
        !file_we && $stable(acc_r))
        else $error("skipped word executed");
    AST_SKIPFLG: assert property ($rose(skip_active) |-> $stable(flg))
        else $error("skip changed flags");
    AST_ADDR: assert property ($past(fetch_req, 2) |->
        file_addr == $past(instr_word[6:0], 2))
        else $error("file address wrong");
    AST_WADDR: assert property (file_we |-> file_addr == $past(file_addr, 2))
        else $error("write address lost");
    AST_FIELDS: assert property ($past(fetch_req) |->
        bit_num == $past(instr_word[9:7]) && lit8 == $past(instr_word[7:0]) &&
        lit11 == $past(instr_word[10:0]))
        else $error("field decode wrong");
    cover property ($rose(skip_active));
    cover property (file_we);
    cover property ($rose(carry_flag));
endmodule // bopd_sva
bind bopd_decoder bopd_sva i_bopd_sva (.*);

// ===== verification/bopd_fmem.sv
`timescale 1ns/1ps
module bopd_fmem (
    input  wire       clk_sys,    // Clock
    input  wire [6:0] file_addr,  // Address
    input  wire       file_we,    // Write strobe
    input  wire [7:0] file_wdata, // Write data
    output wire [7:0] file_rdata  // Read data
);
    reg [7:0] mem [0:127];
    integer i;
    initial for (i = 0; i < 128; i = i + 1) mem[i] = 8'h00;
    // Whole seven-bit range is backed, so boundary addresses read real data
    assign file_rdata = mem[file_addr];
    always @(posedge clk_sys) begin
        if (file_we) begin
            mem[file_addr] <= file_wdata;
        end
    end
endmodule // bopd_fmem

// ===== verification/byte_op_instruction_decoder_tb.sv
`timescale 1ns/1ps
module byte_op_instruction_decoder_tb;
    reg         clk_sys, rst_n;
    reg  [13:0] instr_word;
    wire [7:0]  file_rdata, file_wdata, acc_r;
    wire [6:0]  file_addr;
    wire [1:0]  phase_r;
    wire        fetch_req, file_we, carry_flag, digit_carry_flag, zero_flag, skip_active;
    integer     n_mismatch, n_checks;
    bopd_decoder i_bopd_decoder (.clk_sys(clk_sys), .rst_n(rst_n), .instr_word(instr_word),
        .file_rdata(file_rdata), .fetch_req(fetch_req), .file_addr(file_addr), .bit_num(),
        .lit8(), .lit11(), .file_we(file_we), .file_wdata(file_wdata), .acc_r(acc_r),
        .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
        .skip_active(skip_active), .phase_r(phase_r));
    bopd_fmem i_bopd_fmem (.clk_sys(clk_sys), .file_addr(file_addr), .file_we(file_we),
        .file_wdata(file_wdata), .file_rdata(file_rdata));
    task stop_test; begin
        if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    end endtask
    task chk(input [7:0] got, input [7:0] exp); begin
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    end endtask
    // Present a word while fetch is open, hold it over the taking edge
    task issue(input [13:0] w); integer k; begin
        k = 0;
        while (fetch_req !== 1'b1 && k < 8) begin
            @(posedge clk_sys); #1; k = k + 1;
        end
        if (k == 8) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t fetch never opened", $time);
            stop_test;
        end
        instr_word = w;
        @(posedge clk_sys); #1;
    end endtask
    // First word is executed; its results land at the second word's taking edge
    task op(input [13:0] w, input [13:0] w2, input [7:0] ea, input [2:0] ef,
            input ewe, input [7:0] ewd, input es); begin
        issue(w);
        issue(w2);
        chk(acc_r, ea);
        chk({5'h00, carry_flag, digit_carry_flag, zero_flag}, {5'h00, ef});
        chk({7'h00, file_we}, {7'h00, ewe});
        if (ewe) chk(file_wdata, ewd);
        chk({7'h00, skip_active}, {7'h00, es});
    end endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        rst_n = 1'b0; instr_word = 14'h0000; n_mismatch = 0; n_checks = 0;
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        i_bopd_fmem.mem[7'h10] = 8'h3C; i_bopd_fmem.mem[7'h7F] = 8'hC4;
        i_bopd_fmem.mem[7'h20] = 8'h01; i_bopd_fmem.mem[7'h21] = 8'h05;
        i_bopd_fmem.mem[7'h30] = 8'hF0; i_bopd_fmem.mem[7'h01] = 8'h80;
        chk(acc_r, 8'h00);
        op(14'h0810, 14'h0000, 8'h3C, 3'h0, 1'b0, 8'h00, 1'b0);
        op(14'h077F, 14'h0000, 8'h00, 3'h7, 1'b0, 8'h00, 1'b0);
        op(14'h0410, 14'h0000, 8'h3C, 3'h6, 1'b0, 8'h00, 1'b0);
        op(14'h0530, 14'h0000, 8'h30, 3'h6, 1'b0, 8'h00, 1'b0);
        op(14'h0690, 14'h0000, 8'h30, 3'h6, 1'b1, 8'h0C, 1'b0);
        op(14'h0D01, 14'h0000, 8'h01, 3'h6, 1'b0, 8'h00, 1'b0);
        op(14'h0C10, 14'h0000, 8'h86, 3'h2, 1'b0, 8'h00, 1'b0);
        op(14'h027F, 14'h0000, 8'h3E, 3'h4, 1'b0, 8'h00, 1'b0);
        op(14'h0930, 14'h0000, 8'h0F, 3'h4, 1'b0, 8'h00, 1'b0);
        op(14'h0320, 14'h0000, 8'h00, 3'h5, 1'b0, 8'h00, 1'b0);
        op(14'h0AB0, 14'h0000, 8'h00, 3'h4, 1'b1, 8'hF1, 1'b0);
        op(14'h0F21, 14'h0000, 8'h06, 3'h4, 1'b0, 8'h00, 1'b0);
        op(14'h0BA0, 14'h0810, 8'h06, 3'h4, 1'b1, 8'h00, 1'b1);
        op(14'h00C0, 14'h0000, 8'h06, 3'h4, 1'b1, 8'h06, 1'b0);
        op(14'h0E7F, 14'h0000, 8'h4C, 3'h4, 1'b0, 8'h00, 1'b0);
        op(14'h017F, 14'h0000, 8'h00, 3'h5, 1'b0, 8'h00, 1'b0);
        op(14'h0060, 14'h0000, 8'h00, 3'h5, 1'b0, 8'h00, 1'b0);
        op(14'h01FF, 14'h0000, 8'h00, 3'h5, 1'b1, 8'h00, 1'b0);
        op(14'h3F7F, 14'h0000, 8'h00, 3'h5, 1'b0, 8'h00, 1'b0);
        stop_test;
    end
endmodule // byte_op_instruction_decoder_tb
